//--- rtl/vdc_defs.vh
// register map, field layouts, reset values and counts of the decoder control
`ifndef VDC_DEFS_VH
`define VDC_DEFS_VH
// register byte addresses
`define VDC_A_INPUT      8'h00
`define VDC_A_SCAN       8'h04
`define VDC_A_GAIN       8'h08
`define VDC_A_DECIM      8'h0C
`define VDC_A_ORIENT     8'h10
`define VDC_A_CAPTURE    8'h14
`define VDC_A_STATUS     8'h18
// input register fields
`define VDC_F_CHAN_HI    2
`define VDC_F_SEPVID     4
`define VDC_F_MONO       5
// gain register fields
`define VDC_F_CGAIN      0
`define VDC_F_MGAIN_DIS  1
`define VDC_F_ADAPT      2
`define VDC_F_KILLER     3
// scan register field
`define VDC_F_SCAN_HI    1
// orientation register field
`define VDC_F_FLIP       0
// decimation register fields
`define VDC_F_DROP_HI    5
`define VDC_F_UNIT       8
`define VDC_F_PARITY     9
// capture register fields
`define VDC_F_RUN        0
`define VDC_F_APPLY      1
// scan mode codes
`define VDC_SCAN_NONINT  2'h0
`define VDC_SCAN_INTER   2'h1
`define VDC_SCAN_ALIGNED 2'h2
`define VDC_SCAN_RSVD    2'h3
// mux codes: composite 0..3, separated video 4
`define VDC_MUX_SEPVID   3'h4
// reset values and the reference ceiling
`define VDC_RST_CHAN     3'h1
`define VDC_RST_SCAN     2'h1
`define VDC_RST_GAIN     4'h9
`define VDC_RST_FLIP     1'h1
`define VDC_RST_REF      4'h0
`define VDC_REF_MAX      4'hF
// channel range
`define VDC_CHAN_MIN     3'h1
`define VDC_CHAN_MAX     3'h4
// fields to wait after a channel change
`define VDC_SETTLE_FIELDS 3'h4
// fields per second
`define VDC_FIELDS_PAL   7'h32
`define VDC_FIELDS_NTSC  7'h3C
`endif

//--- rtl/field_decimator.v
// evenly spread dropping of fields or frames
`timescale 1ns/1ps
`default_nettype none
`include "vdc_defs.vh"
module field_decimator (
  // clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // field timing
  input  wire       field_start,
  input  wire       field_odd,
  input  wire       pal_mode,
  // settings, stable between field starts
  input  wire [5:0] drop_count,
  input  wire       unit_fields,
  input  wire       parity_even,
  // decision for the field just starting
  output reg        keep_r
);
  reg  [6:0] acc_r;
  reg  [6:0] acc_nxt;
  reg        synced_r;
  reg        synced_nxt;
  reg        keep_nxt;
  reg        frame_drop_r;
  reg        frame_drop_nxt;
  wire [6:0] total;
  wire [6:0] drop_w;
  wire       first_par;
  wire [7:0] sum;
  reg  [7:0] cfg_r;
  wire [7:0] cfg_w;
  wire       cfg_changed;

  // frames are half as many units as fields
  assign total     = unit_fields ? (pal_mode ? `VDC_FIELDS_PAL : `VDC_FIELDS_NTSC)
                                 : (pal_mode ? `VDC_FIELDS_PAL >> 1 : `VDC_FIELDS_NTSC >> 1);
  assign drop_w    = {1'b0, drop_count};
  assign first_par = (field_odd == ~parity_even);
  assign sum       = {1'b0, acc_r} + {1'b0, drop_w};
  // a new setting forces a fresh parity sync, so alignment always rules
  assign cfg_w       = {unit_fields, parity_even, drop_count};
  assign cfg_changed = (cfg_w != cfg_r);

  // bresenham style accumulator; sync field of chosen parity dropped first
  always @* begin
    acc_nxt        = acc_r;
    synced_nxt     = synced_r;
    keep_nxt       = keep_r;
    frame_drop_nxt = frame_drop_r;
    if (field_start) begin
      if (drop_w == 7'h00) begin
        synced_nxt = 1'b0;
        keep_nxt   = 1'b1;
        acc_nxt    = 7'h00;
      end else if (drop_w >= total) begin
        keep_nxt = 1'b0;
      end else if (!synced_r || cfg_changed) begin
        // wait for the aligned parity so the first field dropped has the chosen parity
        if (first_par) begin
          synced_nxt     = 1'b1;
          acc_nxt        = 7'h00;
          keep_nxt       = 1'b0;
          frame_drop_nxt = 1'b1;
        end else begin
          synced_nxt = 1'b0;
          keep_nxt   = 1'b1;
        end
      end else if (unit_fields || first_par) begin
        // one decision per unit; frames decide at their first field
        if (sum >= {1'b0, total}) begin
          acc_nxt        = sum[6:0] - total;
          keep_nxt       = 1'b0;
          frame_drop_nxt = 1'b1;
        end else begin
          acc_nxt        = sum[6:0];
          keep_nxt       = 1'b1;
          frame_drop_nxt = 1'b0;
        end
      end else begin
        keep_nxt = ~frame_drop_r;
      end
    end
  end

  // state
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_r        <= 7'h00;
      synced_r     <= 1'b0;
      keep_r       <= 1'b1;
      frame_drop_r <= 1'b0;
      cfg_r        <= 8'h00;
    end else begin
      acc_r        <= acc_nxt;
      synced_r     <= synced_nxt;
      keep_r       <= keep_nxt;
      frame_drop_r <= frame_drop_nxt;
      if (field_start)
        cfg_r <= cfg_w;
    end
  end
endmodule
`default_nettype wire

//--- rtl/settle_counter.v
// counts fields after an input switch before images are trusted
`timescale 1ns/1ps
`default_nettype none
`include "vdc_defs.vh"
module settle_counter (
  // clock and reset
  input  wire clock,
  input  wire rst_n,
  // events
  input  wire restart,
  input  wire field_start,
  // status
  output reg  settling_r
);
  reg [2:0] count_r;
  reg [2:0] count_nxt;

  // restart wins over a field start in the same cycle
  always @* begin
    count_nxt = count_r;
    if (restart)
      count_nxt = `VDC_SETTLE_FIELDS;
    else if (field_start && count_r != 3'h0)
      count_nxt = count_r - 3'h1;
  end

  // counter and flag
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r    <= `VDC_SETTLE_FIELDS;
      settling_r <= 1'b1;
    end else begin
      count_r    <= count_nxt;
      settling_r <= (count_nxt != 3'h0);
    end
  end
endmodule
`default_nettype wire

//--- rtl/video_decoder_control.v
// register port and field-synchronous control of the video decoder
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "vdc_defs.vh"
module video_decoder_control (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  // decoder status
  input  wire        field_start,
  input  wire        field_odd,
  input  wire        pal_mode,
  input  wire        adc_overflow,
  input  wire        burst_present,
  // decoder controls
  output reg  [2:0]  mux_select_r,
  output reg         chroma_adc_on_r,
  output reg         notch_enable_r,
  output reg  [1:0]  vscale_mode_r,
  output reg         half_line_shift_r,
  output reg         chroma_gain_on_r,
  output reg         main_gain_on_r,
  output reg         adaptive_gain_r,
  output reg  [3:0]  adc_ref_level_r,
  output reg         color_enable_r,
  // capture controls
  output reg         capture_field_r,
  output reg         image_valid_r,
  output reg         bottom_first_r
);
  // software copies, written any time
  reg  [2:0] sw_chan_r;
  reg        sw_sepvid_r;
  reg        sw_mono_r;
  reg  [1:0] sw_scan_r;
  reg  [3:0] sw_gain_r;
  reg  [5:0] sw_drop_r;
  reg        sw_unit_r;
  reg        sw_par_r;
  reg        sw_flip_r;
  reg        run_r;
  // working copies, loaded at a field start
  reg  [2:0] act_chan_r;
  reg        act_sepvid_r;
  reg        act_mono_r;
  reg  [1:0] act_scan_r;
  reg  [3:0] act_gain_r;
  reg  [5:0] act_drop_r;
  reg        act_unit_r;
  reg        act_par_r;
  reg        field_odd_r;
  reg        field_go_r;
  reg        field_gap_r;
  wire       keep_w;
  wire       settling_w;
  wire       sel_input;
  wire       sel_scan;
  wire       sel_gain;
  wire       sel_decim;
  wire       sel_orient;
  wire       sel_capture;
  wire       sel_status;
  wire       chan_ok;
  wire       route_change;
  wire [2:0] mux_nxt;
  wire [2:0] sw_mux;
  wire       apply_ok;

  // channel number to composite mux code, separated video overrides
  function [2:0] mux_code;
    input [2:0] chan;
    input       sepvid;
    begin
      if (sepvid)
        mux_code = `VDC_MUX_SEPVID;
      else
        mux_code = chan - `VDC_CHAN_MIN;
    end
  endfunction

  // address decode
  // exact match only, so no register shows up under a second address
  assign sel_input   = (addr == `VDC_A_INPUT);
  assign sel_scan    = (addr == `VDC_A_SCAN);
  assign sel_gain    = (addr == `VDC_A_GAIN);
  assign sel_decim   = (addr == `VDC_A_DECIM);
  assign sel_orient  = (addr == `VDC_A_ORIENT);
  assign sel_capture = (addr == `VDC_A_CAPTURE);
  assign sel_status  = (addr == `VDC_A_STATUS);

  // out-of-range channels are ignored so the channel never leaves 1..4
  assign chan_ok = (wdata[`VDC_F_CHAN_HI:0] >= `VDC_CHAN_MIN) &&
                   (wdata[`VDC_F_CHAN_HI:0] <= `VDC_CHAN_MAX);

  // flip only accepted while capture is stopped
  assign apply_ok = wr && sel_capture && wdata[`VDC_F_APPLY] && !run_r;

  // mux route pending and whether it differs from the live one
  // compared at the field start, the edge the working copies take the new route; mux_select_r follows one cycle later
  assign sw_mux       = mux_code(sw_chan_r, sw_sepvid_r);
  assign mux_nxt      = mux_code(act_chan_r, act_sepvid_r);
  assign route_change = field_start && (sw_mux != mux_nxt);

  // software-side register writes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sw_chan_r   <= `VDC_RST_CHAN;
      sw_sepvid_r <= 1'b0;
      sw_mono_r   <= 1'b0;
      sw_scan_r   <= `VDC_RST_SCAN;
      sw_gain_r   <= `VDC_RST_GAIN;
      sw_drop_r   <= 6'h00;
      sw_unit_r   <= 1'b0;
      sw_par_r    <= 1'b0;
      sw_flip_r   <= `VDC_RST_FLIP;
      run_r       <= 1'b0;
    end else if (wr) begin
      if (sel_input) begin
        if (chan_ok)
          sw_chan_r <= wdata[`VDC_F_CHAN_HI:0];
        sw_sepvid_r <= wdata[`VDC_F_SEPVID];
        sw_mono_r   <= wdata[`VDC_F_MONO];
      end
      // the reserved scan code is refused, mode stays as it was
      if (sel_scan && wdata[`VDC_F_SCAN_HI:0] != `VDC_SCAN_RSVD)
        sw_scan_r <= wdata[`VDC_F_SCAN_HI:0];
      // gain options and burst killer share one word
      if (sel_gain)
        sw_gain_r <= wdata[`VDC_F_KILLER:0];
      // drop count, unit and parity reach the decimator at a field
      if (sel_decim) begin
        sw_drop_r <= wdata[`VDC_F_DROP_HI:0];
        sw_unit_r <= wdata[`VDC_F_UNIT];
        sw_par_r  <= wdata[`VDC_F_PARITY];
      end
      // staged flip; line order changes only on an apply
      if (sel_orient)
        sw_flip_r <= wdata[`VDC_F_FLIP];
      // run level; the apply bit is handled beside the line order
      if (sel_capture)
        run_r <= wdata[`VDC_F_RUN];
    end
  end

  // load working copies only between fields, never mid-field
  // so that no field is captured with a mix of old and new settings
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_chan_r   <= `VDC_RST_CHAN;
      act_sepvid_r <= 1'b0;
      act_mono_r   <= 1'b0;
      act_scan_r   <= `VDC_RST_SCAN;
      act_gain_r   <= `VDC_RST_GAIN;
      act_drop_r   <= 6'h00;
      act_unit_r   <= 1'b0;
      act_par_r    <= 1'b0;
    end else if (field_start) begin
      act_chan_r   <= sw_chan_r;
      act_sepvid_r <= sw_sepvid_r;
      act_mono_r   <= sw_mono_r;
      act_scan_r   <= sw_scan_r;
      act_gain_r   <= sw_gain_r;
      act_drop_r   <= sw_drop_r;
      act_unit_r   <= sw_unit_r;
      act_par_r    <= sw_par_r;
    end
  end

  // field parity and start delayed to line up with the keep decision;
  // the second stage marks the cycle in which that decision is fresh
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      field_odd_r <= 1'b1;
      field_go_r  <= 1'b0;
      field_gap_r <= 1'b0;
    end else begin
      field_go_r  <= field_start;
      field_gap_r <= field_go_r;
      if (field_start)
        field_odd_r <= field_odd;
    end
  end

  // dropping decision per field, using the settings of that field
  // the decimator sees each start one cycle late, after the copies load
  field_decimator u_decim (
    .clock       (clock),
    .rst_n       (rst_n),
    .field_start (field_go_r),
    .field_odd   (field_odd_r),
    .pal_mode    (pal_mode),
    .drop_count  (act_drop_r),
    .unit_fields (act_unit_r),
    .parity_even (act_par_r),
    .keep_r      (keep_w)
  );

  // input switch restarts the settling window
  // rewriting the live channel is no switch, so images stay valid
  settle_counter u_settle (
    .clock       (clock),
    .rst_n       (rst_n),
    .restart     (route_change),
    .field_start (field_start),
    .settling_r  (settling_w)
  );

  // decoder path controls follow the working copies
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mux_select_r      <= `VDC_RST_CHAN - `VDC_CHAN_MIN;
      chroma_adc_on_r   <= 1'b0;
      notch_enable_r    <= 1'b1;
      vscale_mode_r     <= `VDC_RST_SCAN;
      half_line_shift_r <= 1'b0;
      chroma_gain_on_r  <= 1'b1;
      main_gain_on_r    <= 1'b1;
      adaptive_gain_r   <= 1'b0;
    end else begin
      mux_select_r     <= mux_nxt;
      // separated video needs the second converter and no notch
      chroma_adc_on_r  <= act_sepvid_r;
      notch_enable_r   <= !act_mono_r && !act_sepvid_r;
      vscale_mode_r    <= act_scan_r;
      // second field moved by half a line so every field lands alike
      half_line_shift_r <= (act_scan_r == `VDC_SCAN_ALIGNED) && !field_odd_r;
      // gain controls follow the working gain word
      chroma_gain_on_r <= act_gain_r[`VDC_F_CGAIN];
      // the disable bit is passed on; software must leave it clear
      main_gain_on_r   <= !act_gain_r[`VDC_F_MGAIN_DIS];
      adaptive_gain_r  <= act_gain_r[`VDC_F_ADAPT];
    end
  end

  // reference level climbs on each overflow, saturating at the top
  // leaving adaptive mode puts the reference back to its rest level
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      adc_ref_level_r <= `VDC_RST_REF;
    end else if (!act_gain_r[`VDC_F_ADAPT]) begin
      adc_ref_level_r <= `VDC_RST_REF;
    end else if (adc_overflow && adc_ref_level_r != `VDC_REF_MAX) begin
      adc_ref_level_r <= adc_ref_level_r + 4'h1;
    end
  end

  // color killer: color off only when checking and burst missing
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      color_enable_r <= 1'b1;
    else
      color_enable_r <= !(act_gain_r[`VDC_F_KILLER] && !burst_present);
  end

  // capture gate per field; kept fields pass in every scan mode
  // a run started mid-field waits for the next decision, so no field
  // has its capture started part-way; clearing run ends capture at once
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      capture_field_r <= 1'b0;
      image_valid_r   <= 1'b0;
    end else begin
      if (!run_r)
        capture_field_r <= 1'b0;
      else if (field_go_r)
        capture_field_r <= 1'b0;
      else if (field_gap_r)
        capture_field_r <= keep_w;
      // images during settling are marked unusable
      image_valid_r <= !settling_w;
    end
  end

  // line order taken from the staged flip only on an accepted apply
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      bottom_first_r <= `VDC_RST_FLIP;
    else if (apply_ok)
      bottom_first_r <= sw_flip_r;
  end

  // read data one cycle after the strobe; unmapped reads give zero
  // status word: [0] settling, [2] image valid, [3] color killed,
  // [4] keep decision, [5] bottom first, [6] field odd, [11:8] reference
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      rdata <= 32'h00000000;
      // channel, separated video and monochrome as written
      if (sel_input)
        rdata <= {26'h0, sw_mono_r, sw_sepvid_r, 1'b0, sw_chan_r};
      // scan code as written, not yet the live one
      if (sel_scan)
        rdata <= {30'h0, sw_scan_r};
      // gain word
      if (sel_gain)
        rdata <= {28'h0, sw_gain_r};
      // decimation setting
      if (sel_decim)
        rdata <= {22'h0, sw_par_r, sw_unit_r, 2'h0, sw_drop_r};
      // staged flip, not the live line order
      if (sel_orient)
        rdata <= {31'h0, sw_flip_r};
      // run level; the apply bit reads back as zero
      if (sel_capture)
        rdata <= {31'h0, run_r};
      // live status
      if (sel_status)
        rdata <= {20'h0, adc_ref_level_r, 1'b0, field_odd_r, bottom_first_r,
                  keep_w, !color_enable_r, image_valid_r, 1'b0, settling_w};
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

//--- dv/vdc_checker.sv
// port assertions for the decoder control block
`timescale 1ns/1ps
`default_nettype none
module vdc_checker (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // decoder status
  input wire logic       field_start,
  input wire logic       adc_overflow,
  input wire logic       burst_present,
  // decoder and capture controls
  input wire logic [2:0] mux_select_r,
  input wire logic       chroma_adc_on_r,
  input wire logic       notch_enable_r,
  input wire logic [1:0] vscale_mode_r,
  input wire logic       half_line_shift_r,
  input wire logic       adaptive_gain_r,
  input wire logic [3:0] adc_ref_level_r,
  input wire logic       color_enable_r,
  input wire logic       capture_field_r,
  input wire logic       image_valid_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_mux_range: assert property (
    mux_select_r <= 3'h4) else $error("mux code out of range");
  chk_sepvid_mux: assert property (
    chroma_adc_on_r |-> mux_select_r == 3'h4) else $error("separated video not routed");
  chk_notch_comp: assert property (
    notch_enable_r |-> !chroma_adc_on_r) else $error("notch on with chroma converter");
  chk_scan_code: assert property (
    vscale_mode_r != 2'h3) else $error("illegal scan code");
  chk_shift_mode: assert property (
    half_line_shift_r |-> vscale_mode_r == 2'h2) else $error("shift outside aligned mode");
  chk_ref_step: assert property (
    adaptive_gain_r && adc_overflow && adc_ref_level_r != 4'hF |=>
    adc_ref_level_r == $past(adc_ref_level_r) + 4'h1 || !adaptive_gain_r)
    else $error("reference did not step");
  chk_ref_clear: assert property (
    !adaptive_gain_r [*2] |-> adc_ref_level_r == 4'h0) else $error("reference not cleared");
  chk_burst_color: assert property (
    burst_present |=> color_enable_r) else $error("color killed with burst");
  chk_capture_gap: assert property (
    field_start |-> ##2 !capture_field_r) else $error("no capture gap at field");
  chk_capture_rise: assert property (
    $rose(capture_field_r) |-> $past(field_start, 3)) else $error("capture rose off field");
  chk_switch_settle: assert property (
    $changed(mux_select_r) |-> ##[0:2] !image_valid_r) else $error("valid kept on switch");
endmodule

bind video_decoder_control vdc_checker u_vdc_checker (
  .clock(clock), .rst_n(rst_n), .field_start(field_start),
  .adc_overflow(adc_overflow), .burst_present(burst_present),
  .mux_select_r(mux_select_r), .chroma_adc_on_r(chroma_adc_on_r),
  .notch_enable_r(notch_enable_r), .vscale_mode_r(vscale_mode_r),
  .half_line_shift_r(half_line_shift_r), .adaptive_gain_r(adaptive_gain_r),
  .adc_ref_level_r(adc_ref_level_r), .color_enable_r(color_enable_r),
  .capture_field_r(capture_field_r), .image_valid_r(image_valid_r));
`default_nettype wire

//--- dv/field_source.sv
// field timing source standing in for the decoder front end
`timescale 1ns/1ps
`default_nettype none
module field_source #(
  parameter int FIELD_CYC = 20
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // field timing
  output logic      field_start,
  output logic      field_odd
);
  int cnt;
  // one-cycle pulse per field, parity alternates; short fields keep the run brief
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      field_start <= 1'b0;
      field_odd <= 1'b0;
    end else begin
      cnt <= (cnt == FIELD_CYC - 1) ? 0 : cnt + 1;
      field_start <= (cnt == FIELD_CYC - 1);
      if (cnt == FIELD_CYC - 1) begin
        field_odd <= !field_odd;
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the decoder control block
`timescale 1ns/1ps
`default_nettype none
`include "vdc_defs.vh"
module tb;
  logic        clock, rst_n, wr, rd, pal_mode, adc_overflow, burst_present, odd;
  logic        field_start, field_odd, chroma_adc_on_r, notch_enable_r, half_line_shift_r;
  logic        chroma_gain_on_r, main_gain_on_r, adaptive_gain_r, color_enable_r;
  logic        capture_field_r, image_valid_r, bottom_first_r;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [2:0]  mux_select_r;
  logic [1:0]  vscale_mode_r;
  logic [3:0]  adc_ref_level_r;
  int          error_cnt, n_checks, cyc, ko, ke;
  // decimation cases: setting, pal, odd kept, even kept out of ten fields
  int          tbl[5][4] = '{'{0, 1, 5, 5}, '{'h319, 1, 5, 0}, '{'h119, 1, 0, 5},
                             '{'h019, 1, 0, 0}, '{'h11E, 0, 0, 5}};

  video_decoder_control u_video_decoder_control (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .field_start(field_start), .field_odd(field_odd),
    .pal_mode(pal_mode), .adc_overflow(adc_overflow), .burst_present(burst_present),
    .mux_select_r(mux_select_r), .chroma_adc_on_r(chroma_adc_on_r),
    .notch_enable_r(notch_enable_r), .vscale_mode_r(vscale_mode_r),
    .half_line_shift_r(half_line_shift_r), .chroma_gain_on_r(chroma_gain_on_r),
    .main_gain_on_r(main_gain_on_r), .adaptive_gain_r(adaptive_gain_r),
    .adc_ref_level_r(adc_ref_level_r), .color_enable_r(color_enable_r),
    .capture_field_r(capture_field_r), .image_valid_r(image_valid_r),
    .bottom_first_r(bottom_first_r));
  field_source u_field_source (
    .clock(clock), .rst_n(rst_n), .field_start(field_start), .field_odd(field_odd));

  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // cycle ceiling well above the expected run of some 2000 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("wrong value at %0t: timeout", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // wait for a field start, then three cycles so the capture level is settled
  task automatic fld();
    do @(negedge clock); while (field_start !== 1'b1);
    odd = field_odd;
    repeat (3) @(negedge clock);
    if (capture_field_r === 1'b1 && odd) ko++;
    if (capture_field_r === 1'b1 && !odd) ke++;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  initial begin
    rst_n = 1'b0;
    {wr, rd, addr, wdata, adc_overflow} = '0;
    {pal_mode, burst_present} = 2'b11;
    {error_cnt, n_checks} = '0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    step(1);
    chk({mux_select_r, vscale_mode_r, notch_enable_r, color_enable_r, bottom_first_r,
         chroma_adc_on_r}, {3'h0, 2'h1, 4'hE});
    rd_chk(`VDC_A_GAIN, 32'h9);
    rd_chk(`VDC_A_INPUT, 32'h1);
    wr_reg(8'h1C, 32'hFFFF);
    rd_chk(8'h1C, 32'h0);
    repeat (3) fld();
    chk(image_valid_r, 32'h0);
    fld();
    chk(image_valid_r, 32'h1);
    // walk every channel; each switch restarts the settling count
    for (int c = 4; c >= 1; c--) begin
      wr_reg(`VDC_A_INPUT, c);
      fld();
      chk(mux_select_r, c - 1);
      chk(image_valid_r, 32'h0);
      repeat (4) fld();
      chk(image_valid_r, 32'h1);
    end
    wr_reg(`VDC_A_INPUT, 32'h5);
    fld();
    chk({mux_select_r, image_valid_r}, {3'h0, 1'b1});
    wr_reg(`VDC_A_INPUT, 32'h11);
    fld();
    chk({mux_select_r, chroma_adc_on_r, notch_enable_r}, {3'h4, 2'b10});
    wr_reg(`VDC_A_INPUT, 32'h21);
    fld();
    chk({mux_select_r, chroma_adc_on_r, notch_enable_r}, 32'h0);
    wr_reg(`VDC_A_INPUT, 32'h1);
    step(2);
    chk(notch_enable_r, 32'h0);
    fld();
    chk(notch_enable_r, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr_reg(`VDC_A_SCAN, s);
      fld();
      chk(vscale_mode_r, (s < 3) ? s : 2);
    end
    repeat (2) begin
      fld();
      chk(half_line_shift_r, !odd);
    end
    wr_reg(`VDC_A_SCAN, 32'h1);
    fld();
    chk(half_line_shift_r, 32'h0);
    // adaptive on, chroma gain and killer off; main gain left on
    wr_reg(`VDC_A_GAIN, 32'h4);
    fld();
    chk({chroma_gain_on_r, main_gain_on_r, adaptive_gain_r}, 32'h3);
    @(posedge clock) adc_overflow <= 1'b1;
    repeat (3) @(posedge clock);
    adc_overflow <= 1'b0;
    step(1);
    chk(adc_ref_level_r, 32'h3);
    @(posedge clock) adc_overflow <= 1'b1;
    repeat (20) @(posedge clock);
    adc_overflow <= 1'b0;
    step(1);
    chk(adc_ref_level_r, 32'hF);
    @(posedge clock) burst_present <= 1'b0;
    step(2);
    chk(color_enable_r, 32'h1);
    wr_reg(`VDC_A_GAIN, 32'h9);
    fld();
    chk({adaptive_gain_r, adc_ref_level_r, color_enable_r}, 32'h0);
    @(posedge clock) burst_present <= 1'b1;
    step(2);
    chk(color_enable_r, 32'h1);
    wr_reg(`VDC_A_CAPTURE, 32'h1);
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      pal_mode <= tbl[i][1][0];
      wr_reg(`VDC_A_DECIM, tbl[i][0]);
      repeat (2) fld();
      {ko, ke} = '0;
      repeat (10) fld();
      chk(ko, tbl[i][2]);
      chk(ke, tbl[i][3]);
    end
    // apply is ignored while running; stop first
    wr_reg(`VDC_A_ORIENT, 32'h0);
    wr_reg(`VDC_A_CAPTURE, 32'h3);
    step(1);
    chk(bottom_first_r, 32'h1);
    wr_reg(`VDC_A_CAPTURE, 32'h0);
    wr_reg(`VDC_A_CAPTURE, 32'h2);
    step(1);
    chk(bottom_first_r, 32'h0);
    rd_chk(`VDC_A_DECIM, 32'h11E);
    rd_chk(`VDC_A_SCAN, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
